// ===== shared/lqc_defs.svh
// Constants for the link quick-configuration decoder
`ifndef LQC_DEFS_SVH
`define LQC_DEFS_SVH
// Register offsets on the control port (byte-style 12-bit address)
`define LQC_ADDR_W        12
`define LQC_OFF_QUICK     12'h05e
`define LQC_OFF_MODE      12'h063
`define LQC_OFF_LANES     12'h06e
`define LQC_OFF_CFG_A     12'h072
`define LQC_OFF_CFG_B     12'h073
// Reset values
`define LQC_RST_QUICK     8'h00
`define LQC_RST_MODE      4'h0
`define LQC_RST_LANES     5'h00
`define LQC_RST_CFG_A     5'h00
`define LQC_RST_CFG_B     5'h00
// Preset codes
`define LQC_CODE_2X8      8'h48
`define LQC_CODE_1H1      8'h81
`define LQC_CODE_1H2      8'h82
`define LQC_CODE_1L1      8'h91
`define LQC_CODE_2H1      8'hc1
`define LQC_CODE_2H2      8'hc2
`define LQC_CODE_2H4      8'hc4
`define LQC_CODE_2L1      8'hd1
`define LQC_CODE_2L2      8'hd2
`define LQC_CODE_2M1      8'he1
`define LQC_CODE_2M2      8'he2
`define LQC_CODE_2M4      8'he4
// Preset field values
`define LQC_MODE_2X       4'h4
`define LQC_MODE_1H       4'h8
`define LQC_MODE_1L       4'h9
`define LQC_MODE_2H       4'hc
`define LQC_MODE_2L       4'hd
`define LQC_MODE_2M       4'he
`define LQC_LANES_1       5'h00
`define LQC_LANES_2       5'h01
`define LQC_LANES_4       5'h03
`define LQC_LANES_8       5'h07
`define LQC_CFG_PRESET    5'h0f
`endif

// ===== shared/lqc_pkg.sv
// Types for the link quick-configuration decoder
package lqc_pkg;
    // One full set of link configuration fields
    typedef struct packed {
        logic [3:0] mode;
        logic [4:0] lanes;
        logic [4:0] cfg_a;
        logic [4:0] cfg_b;
    } lqc_cfg_t;
    // Result of decoding a preset code
    typedef struct packed {
        logic      hit;
        lqc_cfg_t  cfg;
    } lqc_preset_t;
endpackage

// ===== rtl/lqc_preset_rom.sv
// Preset code to configuration lookup
`timescale 1ns/1ps
`include "lqc_defs.svh"
module lqc_preset_rom (
    input  wire logic [7:0]          code,
    output lqc_pkg::lqc_preset_t     preset
);
    // Pack one preset entry
    function automatic lqc_pkg::lqc_preset_t mk(input logic [3:0] m, input logic [4:0] l);
        lqc_pkg::lqc_preset_t p;
        p.hit       = 1'b1;
        p.cfg.mode  = m;
        p.cfg.lanes = l;
        p.cfg.cfg_a = `LQC_CFG_PRESET;
        p.cfg.cfg_b = `LQC_CFG_PRESET;
        return p;
    endfunction

    // Reserved and unlisted codes decode to a miss
    function automatic lqc_pkg::lqc_preset_t lookup(input logic [7:0] c);
        lqc_pkg::lqc_preset_t p;
        p = '0;
        unique case (c)
            `LQC_CODE_2X8: p = mk(`LQC_MODE_2X, `LQC_LANES_8);
            `LQC_CODE_1H1: p = mk(`LQC_MODE_1H, `LQC_LANES_1);
            `LQC_CODE_1H2: p = mk(`LQC_MODE_1H, `LQC_LANES_2);
            `LQC_CODE_1L1: p = mk(`LQC_MODE_1L, `LQC_LANES_1);
            `LQC_CODE_2H1: p = mk(`LQC_MODE_2H, `LQC_LANES_1);
            `LQC_CODE_2H2: p = mk(`LQC_MODE_2H, `LQC_LANES_2);
            `LQC_CODE_2H4: p = mk(`LQC_MODE_2H, `LQC_LANES_4);
            `LQC_CODE_2L1: p = mk(`LQC_MODE_2L, `LQC_LANES_1);
            `LQC_CODE_2L2: p = mk(`LQC_MODE_2L, `LQC_LANES_2);
            `LQC_CODE_2M1: p = mk(`LQC_MODE_2M, `LQC_LANES_1);
            `LQC_CODE_2M2: p = mk(`LQC_MODE_2M, `LQC_LANES_2);
            `LQC_CODE_2M4: p = mk(`LQC_MODE_2M, `LQC_LANES_4);
            default:       p = '0;
        endcase
        return p;
    endfunction

    assign preset = lookup(code);
endmodule

// ===== rtl/lqc_field_reg.sv
// One configuration field with software and preset load paths
`timescale 1ns/1ps
module lqc_field_reg #(
    parameter int          W   = 5,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic          sys_clk,
    input  wire logic          reset_n,
    input  wire logic          clk_en,
    input  wire logic          sw_we,
    input  wire logic [W-1:0]  sw_data,
    input  wire logic          preset_we,
    input  wire logic [W-1:0]  preset_data,
    output logic      [W-1:0]  value
);
    // Preset and direct write never coincide: they decode different addresses
    wire logic [W-1:0] next_value = preset_we ? preset_data : (sw_we ? sw_data : value);

    // Field storage, frozen while the clock enable is low
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            value <= RST;
        end else if (clk_en) begin
            value <= next_value;
        end
    end
endmodule

// ===== rtl/lqc_decoder.sv
// Link quick-configuration register bank with preset decoder
//
// Summary of operation
// - Code 0x48 loads mode 0x4, lanes 0x7, both 5-bit fields 0xF.
// - Code 0x81 loads mode 0x8 and lanes 0x0.
// - Code 0x82 loads mode 0x8 and lanes 0x1.
// - Code 0x91 loads mode 0x9 and lanes 0x0.
// - Code 0xC1 loads mode 0xC and lanes 0x0.
// - Code 0xC2 loads mode 0xC and lanes 0x1.
// - Code 0xC4 loads mode 0xC and lanes 0x3.
// - Code 0xD1 loads mode 0xD and lanes 0x0.
// - Code 0xD2 loads mode 0xD and lanes 0x1.
// - Code 0xE1 loads mode 0xE and lanes 0x0.
// - Code 0xE2 loads mode 0xE and lanes 0x1.
// - Code 0xE4 loads mode 0xE and lanes 0x3.
// - Every converter preset also loads 0xF into both 5-bit fields.
// - Unlisted or reserved codes leave all configuration fields unchanged.
// - Quick register is never stored; always reads 0x00.
// - Quick register drives nothing; it only overwrites the other fields.
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ps
`include "lqc_defs.svh"
module lqc_decoder (
    input  wire logic                     sys_clk,
    input  wire logic                     reset_n,
    input  wire logic                     clk_en,
    input  wire logic [`LQC_ADDR_W-1:0]   reg_addr,
    input  wire logic [7:0]               reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [7:0]               reg_rdata,
    output lqc_pkg::lqc_cfg_t             link_cfg
);
    // Address decode
    wire logic hit_quick = (reg_addr == `LQC_OFF_QUICK);
    wire logic hit_mode  = (reg_addr == `LQC_OFF_MODE);
    wire logic hit_lanes = (reg_addr == `LQC_OFF_LANES);
    wire logic hit_cfg_a = (reg_addr == `LQC_OFF_CFG_A);
    wire logic hit_cfg_b = (reg_addr == `LQC_OFF_CFG_B);

    // Preset lookup on the write data itself, so no staging register exists
    lqc_pkg::lqc_preset_t preset;
    lqc_preset_rom u_rom (
        .code   (reg_wdata),
        .preset (preset)
    );

    // One load strobe shared by all fields keeps a preset atomic
    wire logic preset_load = reg_wr && hit_quick && preset.hit;

    logic [3:0] mode_q;
    logic [4:0] lanes_q;
    logic [4:0] cfg_a_q;
    logic [4:0] cfg_b_q;

    lqc_field_reg #(.W(4), .RST(`LQC_RST_MODE)) u_mode (
        .sys_clk     (sys_clk),
        .reset_n     (reset_n),
        .clk_en      (clk_en),
        .sw_we       (reg_wr && hit_mode),
        .sw_data     (reg_wdata[3:0]),
        .preset_we   (preset_load),
        .preset_data (preset.cfg.mode),
        .value       (mode_q)
    );
    lqc_field_reg #(.W(5), .RST(`LQC_RST_LANES)) u_lanes (
        .sys_clk     (sys_clk),
        .reset_n     (reset_n),
        .clk_en      (clk_en),
        .sw_we       (reg_wr && hit_lanes),
        .sw_data     (reg_wdata[4:0]),
        .preset_we   (preset_load),
        .preset_data (preset.cfg.lanes),
        .value       (lanes_q)
    );
    lqc_field_reg #(.W(5), .RST(`LQC_RST_CFG_A)) u_cfg_a (
        .sys_clk     (sys_clk),
        .reset_n     (reset_n),
        .clk_en      (clk_en),
        .sw_we       (reg_wr && hit_cfg_a),
        .sw_data     (reg_wdata[4:0]),
        .preset_we   (preset_load),
        .preset_data (preset.cfg.cfg_a),
        .value       (cfg_a_q)
    );
    lqc_field_reg #(.W(5), .RST(`LQC_RST_CFG_B)) u_cfg_b (
        .sys_clk     (sys_clk),
        .reset_n     (reset_n),
        .clk_en      (clk_en),
        .sw_we       (reg_wr && hit_cfg_b),
        .sw_data     (reg_wdata[4:0]),
        .preset_we   (preset_load),
        .preset_data (preset.cfg.cfg_b),
        .value       (cfg_b_q)
    );

    // Read mux; quick register is never stored, it reads as its reset value
    wire logic [7:0] rd_sel =
        hit_quick ? `LQC_RST_QUICK :
        hit_mode  ? {4'h0, mode_q} :
        hit_lanes ? {3'h0, lanes_q} :
        hit_cfg_a ? {3'h0, cfg_a_q} :
        hit_cfg_b ? {3'h0, cfg_b_q} : 8'h00;         // Unmapped reads zero
    wire logic [7:0] next_rdata = reg_rd ? rd_sel : 8'h00;

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            reg_rdata <= next_rdata;
        end
    end

    // Registered copy of the fields, so the outputs come from flops
    wire lqc_pkg::lqc_cfg_t next_cfg = '{mode: mode_q, lanes: lanes_q, cfg_a: cfg_a_q, cfg_b: cfg_b_q};
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            link_cfg <= '0;
        end else if (clk_en) begin
            link_cfg <= next_cfg;
        end
    end
endmodule

// ===== dv/lqc_decoder_checker.sv
// Port assertions for the quick-configuration decoder
`timescale 1ns/1ps
module lqc_checker (
    input wire logic              sys_clk,
    input wire logic              reset_n,
    input wire logic              clk_en,
    input wire logic [11:0]       reg_addr,
    input wire logic [7:0]        reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [7:0]        reg_rdata,
    input wire lqc_pkg::lqc_cfg_t link_cfg
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // Accepted quick-register strobes; both 5-bit fields go to 0xF on a preset
    localparam logic [9:0] PAIR_F = 10'h1ef;
    wire q_wr = clk_en && reg_wr && reg_addr == 12'h05e;
    wire q_rd = clk_en && reg_rd && reg_addr == 12'h05e;
    // Mode and lanes as one 9-bit value; link_cfg copies the fields one edge late
    chk_code_48: assert property (q_wr && reg_wdata == 8'h48 ##1 clk_en |=> link_cfg == {9'h087, PAIR_F})
        else $error("preset 48 wrong");
    chk_code_81: assert property (q_wr && reg_wdata == 8'h81 ##1 clk_en |=> link_cfg == {9'h100, PAIR_F})
        else $error("preset 81 wrong");
    chk_code_c4: assert property (q_wr && reg_wdata == 8'hc4 ##1 clk_en |=> link_cfg == {9'h183, PAIR_F})
        else $error("preset c4 wrong");
    chk_code_d2: assert property (q_wr && reg_wdata == 8'hd2 ##1 clk_en |=> link_cfg == {9'h1a1, PAIR_F})
        else $error("preset d2 wrong");
    chk_code_e4: assert property (q_wr && reg_wdata == 8'he4 ##1 clk_en |=> link_cfg == {9'h1c3, PAIR_F})
        else $error("preset e4 wrong");
    chk_reserved_hold: assert property (q_wr && (reg_wdata == 8'h42 || reg_wdata == 8'h44) |=> ##1 $stable(link_cfg))
        else $error("reserved code changed fields");
    chk_quick_zero: assert property (q_rd |=> reg_rdata == 8'h00)
        else $error("quick register read not zero");
    // Read data stands for one cycle only
    chk_rdata_idle: assert property (clk_en && !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
    chk_freeze_cfg: assert property (!clk_en |=> $stable(link_cfg) && $stable(reg_rdata))
        else $error("state moved with clock disabled");
endmodule
bind lqc_decoder lqc_checker u_chk (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .link_cfg(link_cfg));

// ===== dv/lqc_host.sv
// Host-side model that drives the control port
`timescale 1ns/1ps
module lqc_host (
    input  wire logic        sys_clk,
    input  wire logic [7:0]  reg_rdata,
    output logic      [11:0] reg_addr,
    output logic      [7:0]  reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd
);
    // Quiet bus at time zero
    initial begin
        reg_addr = 12'h000;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // Write strobe stays up on return so writes can follow with no gap
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        #1;
    endtask
    // Preset code goes to the quick register first, adjustments after
    task automatic preset(input logic [7:0] c);
        wr(12'h05e, c);
    endtask
    // Read data is taken in the cycle after the strobe, the only one it stands in
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    // Idle cycle; stale write data is scrambled so it never looks valid
    task automatic idle();
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_wdata <= ~reg_wdata;
        @(posedge sys_clk);
        #1;
    endtask
endmodule

// ===== dv/tb_top.sv
// Self-checking bench for the quick-configuration decoder
`timescale 1ns/1ps
module tb_top;
    logic              sys_clk, reset_n, clk_en, reg_wr, reg_rd;
    logic [11:0]       reg_addr;
    logic [7:0]        reg_wdata, reg_rdata, rdv;
    lqc_pkg::lqc_cfg_t link_cfg, held;
    int                err_count = 0;
    int                total_checks = 0;
    int                cycles = 0;
    // Codes with mode in the top four bits and lanes below
    localparam logic [7:0] CODES [12] = '{8'h48, 8'h81, 8'h82, 8'h91, 8'hc1, 8'hc2, 8'hc4, 8'hd1, 8'hd2, 8'he1,
        8'he2, 8'he4};
    localparam logic [8:0] ML [12] = '{9'h087, 9'h100, 9'h101, 9'h120, 9'h180, 9'h181, 9'h183, 9'h1a0, 9'h1a1,
        9'h1c0, 9'h1c1, 9'h1c3};
    localparam logic [7:0] BAD [7] = '{8'h42, 8'h44, 8'h00, 8'h01, 8'h02, 8'h08, 8'hff};
    lqc_decoder u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_cfg(link_cfg));
    lqc_host u_host (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd));
    task automatic check(input string what, input logic [18:0] seen, input logic [18:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Hang guard, far above the fewer than a hundred cycles the sequence needs
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            report_and_stop();
        end
    end
    initial begin
        reset_n = 1'b0;
        clk_en = 1'b1;
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        #1;
        check("reset cfg", link_cfg, 19'h00000);
        u_host.rd(12'h05e, rdv);
        check("quick reset", 19'(rdv), 19'h00000);
        // Each preset lands over a cleared field written back to back before it
        foreach (CODES[i]) begin
            u_host.wr(12'h072, 8'h00);
            u_host.preset(CODES[i]);
            u_host.idle();
            check("preset cfg", link_cfg, {ML[i], 10'h1ef});
            u_host.rd(12'h063, rdv);
            check("mode read", 19'(rdv), 19'(ML[i][8:5]));
            u_host.rd(12'h05e, rdv);
            check("quick read", 19'(rdv), 19'h00000);
        end
        // Unlisted codes, a disabled clock and an unmapped address change nothing
        held = link_cfg;
        foreach (BAD[i]) begin
            u_host.preset(BAD[i]);
            u_host.idle();
            check("unlisted code", link_cfg, held);
        end
        clk_en <= 1'b0;
        u_host.preset(8'h81);
        clk_en <= 1'b1;
        u_host.wr(12'h100, 8'h81);
        u_host.rd(12'h100, rdv);
        check("unmapped read", 19'(rdv), 19'h00000);
        u_host.idle();
        check("frozen write", link_cfg, held);
        // A field written after its preset keeps the written value
        u_host.preset(8'hc4);
        u_host.wr(12'h06e, 8'h05);
        u_host.idle();
        check("adjust after preset", link_cfg, {4'hc, 5'h05, 10'h1ef});
        // Direct field writes and read-back of lanes, cfg_a and cfg_b after a preset
        u_host.wr(12'h073, 8'h03);
        u_host.rd(12'h072, rdv);
        check("cfg_a read", 19'(rdv), 19'h0000f);
        u_host.rd(12'h073, rdv);
        check("cfg_b read", 19'(rdv), 19'h00003);
        u_host.rd(12'h06e, rdv);
        check("lanes read", 19'(rdv), 19'h00005);
        u_host.idle();
        check("cfg after direct write", link_cfg, {4'hc, 5'h05, 5'h0f, 5'h03});
        report_and_stop();
    end
endmodule
